// [hw/erb_array.sv]
// Storage array of the embedded RAM block, two write ports, registered read data
`timescale 1ns/1ps
module erb_array
  import erb_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int AW = 10,
  parameter int WIDTH = 20
)
(
  input wire logic core_clk,
  input wire logic clk_en,
  input wire logic a_wr,
  input wire logic [AW-1:0] a_addr,
  input wire logic [WIDTH-1:0] a_wdata,
  input wire logic b_wr,
  input wire logic [AW-1:0] b_addr,
  input wire logic [WIDTH-1:0] b_wdata,
  input wire logic [AW-1:0] ra_addr,
  input wire logic [AW-1:0] rb_addr,
  output logic [WIDTH-1:0] ra_data,
  output logic [WIDTH-1:0] rb_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  wire collide = a_wr && b_wr && (a_addr == b_addr);

  // ------------------------------------------------------------
  // Write and read
  // ------------------------------------------------------------
  // No arbitration: a same-address double write leaves the word unknown
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      if (collide)
        mem[a_addr] <= 'x;
      else
      begin
        if (a_wr)
          mem[a_addr] <= a_wdata;
        if (b_wr)
          mem[b_addr] <= b_wdata;
      end
      // Reads see the word held before this edge's writes
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end
endmodule : erb_array

// [hw/erb_pkg.sv]
// Constants and types for the embedded RAM block
package erb_pkg;
  // ------------------------------------------------------------
  // Organisation
  // ------------------------------------------------------------
  localparam int ERB_LARGE_BITS = 20480;
  localparam int ERB_LARGE_WIDTH = 20;
  localparam int ERB_LARGE_DEPTH = 1024;
  localparam int ERB_LARGE_AW = 10;
  localparam int ERB_SMALL_BITS = 640;
  localparam int ERB_MODULES = 10;
  localparam int ERB_S32_DEPTH = 32;
  localparam int ERB_S32_SLICE = 2;
  localparam int ERB_S64_DEPTH = 64;
  localparam int ERB_S64_SLICE = 1;
  localparam int ERB_MAX_WIDTH = 20;
  localparam int ERB_MAX_AW = 10;
  localparam logic [ERB_MAX_WIDTH-1:0] ERB_OUT_RESET = 20'h0_0000;

  typedef enum logic [1:0] {
    erb_large_ram_block,
    erb_small_32x20,
    erb_small_64x10
  } erb_kind_t;

  typedef enum logic [1:0] {
    erb_single_port,
    erb_simple_dual_port,
    erb_true_dual_port
  } erb_port_mode_t;

  typedef enum logic {
    erb_rdw_new_data,
    erb_rdw_old_data
  } erb_rdw_t;
endpackage : erb_pkg

// [hw/erb_ram.sv]
// Top of the embedded RAM block: organisation, port modes, output registers
// How it works
// - Large flavour stores 20 Kb with two independent ports.
// - Small flavour holds 640 bits, ten logic modules of one array block.
// - Small flavour may be ten 32x2 slices: a 32x20 simple dual port.
// - Small flavour may be ten 64x1 slices: a 64x10 simple dual port.
// - Small flavour has no native single port; a wrapper emulates it.
// - Small flavour registers data in/out; read address from neighbours.
// - Small flavour write address and read data registers stay internal.
// - Same-address writes from both ports are not arbitrated; word is unknown.
// - Large block same-port new-data mode returns the word being written.
// - Mixed-port old-data mode returns the word before the concurrent write.
// - Output registers clear to zero at reset, whatever the contents.
`timescale 1ns/1ps
module erb_ram
  import erb_pkg::*;
#(
  parameter erb_kind_t KIND = erb_large_ram_block,
  parameter erb_port_mode_t PORT_MODE = erb_true_dual_port,
  parameter erb_rdw_t SAME_PORT_RDW = erb_rdw_new_data
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic a_wr,
  input wire logic [ERB_MAX_AW-1:0] a_addr,
  input wire logic [ERB_MAX_WIDTH-1:0] a_wdata,
  input wire logic b_rd,
  input wire logic b_wr,
  input wire logic [ERB_MAX_AW-1:0] b_addr,
  input wire logic [ERB_MAX_WIDTH-1:0] b_wdata,
  output logic [ERB_MAX_WIDTH-1:0] a_rdata,
  output logic [ERB_MAX_WIDTH-1:0] b_rdata
);
  // ------------------------------------------------------------
  // Organisation chosen at build time
  // ------------------------------------------------------------
  localparam bit IS_LARGE = (KIND == erb_large_ram_block);
  localparam int WIDTH = IS_LARGE ? ERB_LARGE_WIDTH :
    (KIND == erb_small_32x20) ? ERB_MODULES * ERB_S32_SLICE :
    ERB_MODULES * ERB_S64_SLICE;
  localparam int DEPTH = IS_LARGE ? ERB_LARGE_DEPTH :
    (KIND == erb_small_32x20) ? ERB_S32_DEPTH : ERB_S64_DEPTH;
  localparam int AW = $clog2(DEPTH);
  // Small flavour offers only simple dual port; true dual port falls back
  localparam bit TRUE_DP = IS_LARGE && (PORT_MODE == erb_true_dual_port);
  localparam bit SINGLE = (PORT_MODE == erb_single_port);

  function automatic logic [ERB_MAX_WIDTH-1:0] erb_widen(input logic [WIDTH-1:0] d);
    logic [ERB_MAX_WIDTH-1:0] r;
    r = '0;
    r[WIDTH-1:0] = d;
    return r;
  endfunction : erb_widen

  // Port B follows port A when single port is emulated
  function automatic logic [AW-1:0] erb_pick_addr(input logic [AW-1:0] a,
    input logic [AW-1:0] b);
    return SINGLE ? a : b;
  endfunction : erb_pick_addr

  function automatic logic [WIDTH-1:0] erb_pick_data(input logic [WIDTH-1:0] a,
    input logic [WIDTH-1:0] b);
    return SINGLE ? a : b;
  endfunction : erb_pick_data

  function automatic logic erb_pick_bit(input logic a, input logic b);
    return SINGLE ? a : b;
  endfunction : erb_pick_bit

  // ------------------------------------------------------------
  // Input registers
  // ------------------------------------------------------------
  // Small flavour: data-in register inside the block, read address held
  // in neighbouring logic; both modelled here as plain flops
  logic q_a_wr;
  logic q_b_wr;
  logic q_b_rd;
  logic [AW-1:0] q_a_addr;
  logic [AW-1:0] q_b_addr;
  logic [WIDTH-1:0] q_a_wdata;
  logic [WIDTH-1:0] q_b_wdata;

  // Port B writes only on the large block in true dual port
  wire next_q_b_wr = TRUE_DP && b_wr;
  wire [AW-1:0] next_q_a_addr = a_addr[AW-1:0];
  wire [AW-1:0] next_q_b_addr = b_addr[AW-1:0];
  wire [WIDTH-1:0] next_q_a_wdata = a_wdata[WIDTH-1:0];
  wire [WIDTH-1:0] next_q_b_wdata = b_wdata[WIDTH-1:0];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q_a_wr <= 1'b0;
      q_b_wr <= 1'b0;
      q_b_rd <= 1'b0;
    end
    else if (clk_en)
    begin
      q_a_wr <= a_wr;
      q_b_wr <= next_q_b_wr;
      q_b_rd <= b_rd;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q_a_addr <= '0;
      q_b_addr <= '0;
    end
    else if (clk_en)
    begin
      q_a_addr <= next_q_a_addr;
      q_b_addr <= next_q_b_addr;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q_a_wdata <= '0;
      q_b_wdata <= '0;
    end
    else if (clk_en)
    begin
      q_a_wdata <= next_q_a_wdata;
      q_b_wdata <= next_q_b_wdata;
    end
  end

  // ------------------------------------------------------------
  // Array
  // ------------------------------------------------------------
  // Single port emulation: port B reads through port A's address
  wire [AW-1:0] rb_sel = erb_pick_addr(q_a_addr, q_b_addr);
  wire [WIDTH-1:0] arr_a;
  wire [WIDTH-1:0] arr_b;

  erb_array #(
    .DEPTH(DEPTH),
    .AW(AW),
    .WIDTH(WIDTH)
  ) u_array (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .a_wr(q_a_wr),
    .a_addr(q_a_addr),
    .a_wdata(q_a_wdata),
    .b_wr(q_b_wr),
    .b_addr(q_b_addr),
    .b_wdata(q_b_wdata),
    .ra_addr(q_a_addr),
    .rb_addr(rb_sel),
    .ra_data(arr_a),
    .rb_data(arr_b)
  );

  // ------------------------------------------------------------
  // Same-port flow-through and output select
  // ------------------------------------------------------------
  // Array read data lag the input stage by a cycle, so the flow-through
  // copy of the written word is held one cycle to line up
  logic fa_hit;
  logic fb_hit;
  logic [WIDTH-1:0] fa_data;
  logic [WIDTH-1:0] fb_data;
  wire new_ok = IS_LARGE && (SAME_PORT_RDW == erb_rdw_new_data);
  wire next_fa_hit = new_ok && q_a_wr;
  wire next_fb_hit = new_ok && erb_pick_bit(q_a_wr, q_b_wr);
  wire [WIDTH-1:0] next_fb_data = erb_pick_data(q_a_wdata, q_b_wdata);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fa_hit <= 1'b0;
      fb_hit <= 1'b0;
    end
    else if (clk_en)
    begin
      fa_hit <= next_fa_hit;
      fb_hit <= next_fb_hit;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fa_data <= '0;
      fb_data <= '0;
    end
    else if (clk_en)
    begin
      fa_data <= q_a_wdata;
      fb_data <= next_fb_data;
    end
  end

  wire [WIDTH-1:0] sel_a = fa_hit ? fa_data : arr_a;
  wire [WIDTH-1:0] sel_b = fb_hit ? fb_data : arr_b;

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  // Port B holds its last word between reads, saving toggles when idle; single port reloads it every enabled cycle
  logic q_b_rd_d;
  wire next_q_b_rd_d = q_b_rd || SINGLE;
  wire [ERB_MAX_WIDTH-1:0] next_a_rdata = erb_widen(sel_a);
  wire [ERB_MAX_WIDTH-1:0] next_b_rdata = erb_widen(sel_b);

  always_ff @(posedge core_clk)
  begin
    if (reset)
      q_b_rd_d <= 1'b0;
    else if (clk_en)
      q_b_rd_d <= next_q_b_rd_d;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      a_rdata <= ERB_OUT_RESET;
    else if (clk_en)
      a_rdata <= next_a_rdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      b_rdata <= ERB_OUT_RESET;
    else if (clk_en && q_b_rd_d)
      b_rdata <= next_b_rdata;
  end
endmodule : erb_ram

// [verif/erb_ram_properties.sv]
// Port checker for the embedded RAM block
`timescale 1ns/1ps
module erb_ram_properties
  import erb_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic a_wr,
  input wire logic [ERB_MAX_AW-1:0] a_addr,
  input wire logic [ERB_MAX_WIDTH-1:0] a_wdata,
  input wire logic b_rd,
  input wire logic b_wr,
  input wire logic [ERB_MAX_AW-1:0] b_addr,
  input wire logic [ERB_MAX_WIDTH-1:0] b_wdata,
  input wire logic [ERB_MAX_WIDTH-1:0] a_rdata,
  input wire logic [ERB_MAX_WIDTH-1:0] b_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_a_wr;
    clk_en && a_wr ##1 clk_en[*2];
  endsequence
  sequence s_rd_after_wr;
    clk_en && a_wr ##1 clk_en && !a_wr && !b_wr && $stable(a_addr) ##1 clk_en[*2];
  endsequence
  AST_CLEAR_A: assert property (disable iff (1'b0) reset && clk_en |=> a_rdata == '0)
    else $error("a_rdata not cleared");
  AST_CLEAR_B: assert property (disable iff (1'b0) reset && clk_en |=> b_rdata == '0)
    else $error("b_rdata not cleared");
  AST_FREEZE_A: assert property (!clk_en |=> $stable(a_rdata))
    else $error("a_rdata moved while frozen");
  AST_FREEZE_B: assert property (!clk_en |=> $stable(b_rdata))
    else $error("b_rdata moved while frozen");
  AST_B_HOLD: assert property (clk_en && !b_rd ##1 clk_en[*2] |=> $stable(b_rdata))
    else $error("b_rdata moved without read");
  AST_A_NEW: assert property (s_a_wr |=> a_rdata == $past(a_wdata, 3))
    else $error("a_rdata not new data");
  AST_B_NEW: assert property (clk_en && b_wr && b_rd ##1 clk_en[*2] |=>
    b_rdata == $past(b_wdata, 3)) else $error("b_rdata not new data");
  AST_READBACK: assert property (s_rd_after_wr |=> a_rdata == $past(a_wdata, 4))
    else $error("readback wrong");
endmodule : erb_ram_properties

bind erb_ram erb_ram_properties u_props (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .a_wr(a_wr), .a_addr(a_addr), .a_wdata(a_wdata), .b_rd(b_rd), .b_wr(b_wr), .b_addr(b_addr),
  .b_wdata(b_wdata), .a_rdata(a_rdata), .b_rdata(b_rdata));

// [verif/erb_user_model.sv]
// User logic in front of port B with its own collision guard
`timescale 1ns/1ps
module erb_user_model
  import erb_pkg::*;
(
  input wire logic a_wr,
  input wire logic [ERB_MAX_AW-1:0] a_addr,
  input wire logic b_wr_req,
  input wire logic [ERB_MAX_AW-1:0] b_addr,
  output logic b_wr
);
  // Port A wins, since the array would store an unknown word
  assign b_wr = b_wr_req && !(a_wr && a_addr == b_addr);
endmodule : erb_user_model

// [verif/tb_embedded_ram_block.sv]
// Self-checking bench for the embedded RAM block
`timescale 1ns/1ps
module tb_embedded_ram_block
  import erb_pkg::*;
();
  logic core_clk = 0, reset = 1, clk_en = 1, a_wr = 0, b_rd = 0, b_req = 0, b_wr, live = 0;
  logic [ERB_MAX_AW-1:0] a_addr = '0, b_addr = '0;
  logic [19:0] a_wdata = '0, b_wdata = '0, a_rdata, b_rdata, mem [16], qa [$], qb [$];
  logic [3:0] pa = '0, pb = '0;
  logic [31:0] seed = 32'h2b51_a55b;
  int fails = 0, n_compared = 0;
  always #20 core_clk = ~core_clk;
  erb_user_model u_user (.a_wr(a_wr), .a_addr(a_addr), .b_wr_req(b_req), .b_addr(b_addr),
    .b_wr(b_wr));
  erb_ram DUT (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .a_wr(a_wr),
    .a_addr(a_addr), .a_wdata(a_wdata), .b_rd(b_rd), .b_wr(b_wr), .b_addr(b_addr),
    .b_wdata(b_wdata), .a_rdata(a_rdata), .b_rdata(b_rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic check(input logic [19:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic step(input logic en, aw, br, bw, input logic [3:0] aa, ba,
    input logic [19:0] ad, bd);
    logic bwe;
    @(posedge core_clk);
    live <= 1;
    clk_en <= en;
    a_wr <= aw;
    b_rd <= br;
    b_req <= bw;
    a_addr <= ERB_MAX_AW'(aa);
    b_addr <= ERB_MAX_AW'(ba);
    a_wdata <= ad;
    b_wdata <= bd;
    bwe = bw && !(aw && aa == ba);
    if (en)
    begin
      qa.push_back(aw ? ad : mem[aa]);
      if (br) qb.push_back(bwe ? bd : mem[ba]);
      if (aw) mem[aa] = ad;
      if (bwe) mem[ba] = bd;
    end
  endtask : step
  // Results land three enabled edges after the request
  always @(posedge core_clk)
  begin
    if (!reset && clk_en)
    begin
      pa = {pa[2:0], live};
      pb = {pb[2:0], live && b_rd};
      #1;
      if (pa[2]) check(a_rdata, qa.pop_front());
      if (pb[2]) check(b_rdata, qb.pop_front());
    end
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1;
    check(a_rdata, '0);
    check(b_rdata, '0);
    reset <= 0;
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      step(1, 1, 1, 1, 4'(i), 4'(i + 8), seed[19:0], seed[31:12]);
    end
    $display("test fill done");
    step(1, 1, 1, 0, 3, 3, 20'h5_a5a5, 20'h0_0000);
    step(1, 1, 1, 1, 5, 5, 20'hc_3c3c, 20'h3_c3c3);
    step(1, 0, 1, 0, 3, 5, 20'h0_0000, 20'h0_0000);
    $display("test mixed port done");
    for (int i = 0; i < 300; i++)
    begin
      seed = lfsr(seed);
      step(|seed[2:0], seed[3], seed[4], seed[5], seed[9:6], seed[13:10], seed[31:12],
        seed[19:0]);
    end
    @(posedge core_clk);
    live <= 0;
    clk_en <= 1;
    repeat (6) @(posedge core_clk);
    $display("test random done");
    wrap_up();
  end
  initial
  begin
    repeat (1000) @(posedge core_clk);
    fails++;
    wrap_up();
  end
endmodule : tb_embedded_ram_block
